// *** hw/cut_pkg.sv ***
// Package for the core up/down timer: register map, field layout, reset values.
// Assumes a 32-bit APB slave on pclk at 25 MHz.
package cut_pkg;
  localparam int          CUT_ADDR_W       = 4;
  localparam logic [3:0]  CUT_CTRL_OFS     = 4'h0;
  localparam logic [3:0]  CUT_TIMER_OFS    = 4'h4;
  localparam logic [15:0] CUT_CTRL_RST     = 16'h0000;
  localparam logic [15:0] CUT_TIMER_RST    = 16'h0000;
  localparam logic [10:0] CUT_CTRL_MASK    = 11'h7FF;
  // Control field positions
  localparam int          CUT_ISEL_LSB     = 0;
  localparam int          CUT_MODE_LSB     = 3;
  localparam int          CUT_RUN_BIT      = 6;
  localparam int          CUT_DIR_BIT      = 7;
  localparam int          CUT_EXTDIR_BIT   = 8;
  localparam int          CUT_TOE_BIT      = 9;
  localparam int          CUT_TLATCH_BIT   = 10;
  // Mode encodings
  localparam logic [2:0]  CUT_MODE_TIMER   = 3'h0;
  localparam logic [2:0]  CUT_MODE_COUNTER = 3'h1;
  localparam logic [2:0]  CUT_MODE_GATE_LO = 3'h2;
  localparam logic [2:0]  CUT_MODE_GATE_HI = 3'h3;
  // Counter-mode edge codes
  localparam logic [2:0]  CUT_EDGE_NONE    = 3'h0;
  localparam logic [2:0]  CUT_EDGE_RISE    = 3'h1;
  localparam logic [2:0]  CUT_EDGE_FALL    = 3'h2;
  localparam logic [2:0]  CUT_EDGE_BOTH    = 3'h3;
  // Smallest prescale factor is 2**3 = 8
  localparam int          CUT_PRE_BASE_LOG = 3;
  localparam int          CUT_PRE_W        = 10;
endpackage

// *** hw/cut_sync.sv ***
// Two-flop synchroniser for one pin.
// Assumes the pin may change at any time relative to pclk.
`timescale 1ns/1ps
module cut_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Data
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// *** hw/cut_core_timer.sv ***
// Core up/down timer with APB register access and toggle latch output.
// Assumes gate, direction and count pins are asynchronous and slow.
`timescale 1ns/1ps
module cut_core_timer
  import cut_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  // APB
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // External pins
  input  wire logic                    count_gate_input_pin,
  input  wire logic                    direction_input_pin,
  input  wire logic                    gpio_out,
  output logic                         toggle_output_pin,
  // Internal routing to auxiliary timers
  output logic                         toggle_latch_out,
  output logic                         wrap_pulse
);
  import cut_pkg::*;

  logic [10:0]          ctrl_q;
  logic [10:0]          ctrl_d;
  logic [TIMER_W-1:0]   timer_q;
  logic [TIMER_W-1:0]   timer_d;
  logic [CUT_PRE_W-1:0] pre_q;
  logic                 gate_s;
  logic                 dir_s;
  logic                 cnt_s;
  logic                 cnt_prev_q;

  // Synchronise pins before use
  cut_sync u_sync_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (count_gate_input_pin),
    .q       (gate_s)
  );
  cut_sync u_sync_dir (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (direction_input_pin),
    .q       (dir_s)
  );
  cut_sync u_sync_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (count_gate_input_pin),
    .q       (cnt_s)
  );

  // Field decode
  wire [2:0] isel_w   = ctrl_q[CUT_ISEL_LSB +: 3];
  wire [2:0] mode_w   = ctrl_q[CUT_MODE_LSB +: 3];
  wire       run_w    = ctrl_q[CUT_RUN_BIT];
  wire       dirbit_w = ctrl_q[CUT_DIR_BIT];
  wire       extdir_w = ctrl_q[CUT_EXTDIR_BIT];
  wire       toe_w    = ctrl_q[CUT_TOE_BIT];
  wire       latch_w  = ctrl_q[CUT_TLATCH_BIT];

  // APB decode; single-cycle access phase, zero wait states
  wire access_w  = psel && penable;
  wire setup_w   = psel && !penable;
  wire wr_w      = access_w && pwrite;
  wire hit_ctrl  = paddr[CUT_ADDR_W-1:0] == CUT_CTRL_OFS;
  wire hit_timer = paddr[CUT_ADDR_W-1:0] == CUT_TIMER_OFS;
  wire mapped_w  = (hit_ctrl || hit_timer) && (paddr[31:CUT_ADDR_W] == '0);
  wire wr_ctrl   = wr_w && mapped_w && hit_ctrl && pstrb[0];
  wire wr_ctrl_h = wr_w && mapped_w && hit_ctrl && pstrb[1];
  wire wr_tmr_l  = wr_w && mapped_w && hit_timer && pstrb[0];
  wire wr_tmr_h  = wr_w && mapped_w && hit_timer && pstrb[1];

  // Direction: 1 means count down; pin sense flipped by the bit
  wire down_w = extdir_w ? (dir_s ^ dirbit_w) : dirbit_w;

  // Free-running prescaler; tick when the selected low bits are all ones
  wire [3:0] pre_sel_w = 4'(CUT_PRE_BASE_LOG) + {1'b0, isel_w};
  wire [CUT_PRE_W-1:0] pre_mask_w =
    CUT_PRE_W'((32'h1 << pre_sel_w) - 32'h1);
  wire pre_tick_w = (pre_q & pre_mask_w) == pre_mask_w;

  // Edge detect on successive synchronised samples
  wire rise_w = cnt_s && !cnt_prev_q;
  wire fall_w = !cnt_s && cnt_prev_q;
  logic edge_hit_w;
  always_comb begin
    unique case (isel_w)
      CUT_EDGE_RISE: edge_hit_w = rise_w;
      CUT_EDGE_FALL: edge_hit_w = fall_w;
      CUT_EDGE_BOTH: edge_hit_w = rise_w || fall_w;
      default:       edge_hit_w = 1'b0;
    endcase
  end

  // Count enable by mode; gate level gives no event of its own
  logic step_w;
  always_comb begin
    unique case (mode_w)
      CUT_MODE_TIMER:   step_w = run_w && pre_tick_w;
      CUT_MODE_COUNTER: step_w = run_w && edge_hit_w;
      CUT_MODE_GATE_LO,
      CUT_MODE_GATE_HI: step_w = run_w && pre_tick_w
                                 && (gate_s == mode_w[0]);
      default:          step_w = 1'b0;
    endcase
  end

  // Wrap detection
  wire wrap_w = step_w && (down_w ? (timer_q == '0) : (timer_q == '1));

  // Timer next value; software write has priority over a count step
  always_comb begin
    timer_d = timer_q;
    if (step_w) begin
      timer_d = down_w ? timer_q - TIMER_W'(1) : timer_q + TIMER_W'(1);
    end
    if (wr_tmr_l || wr_tmr_h) begin
      timer_d = timer_q;
      if (wr_tmr_l) begin
        timer_d[7:0] = pwdata[7:0];
      end
      if (wr_tmr_h) begin
        timer_d[TIMER_W-1:8] = pwdata[TIMER_W-1:8];
      end
    end
  end

  // Control next value; a software write of the latch beats a wrap toggle
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrap_w) begin
      ctrl_d[CUT_TLATCH_BIT] = !latch_w;
    end
    if (wr_ctrl) begin
      ctrl_d[7:0] = pwdata[7:0];
    end
    if (wr_ctrl_h) begin
      ctrl_d[10:8] = pwdata[10:8];
    end
  end

  // Read mux
  wire [31:0] rdata_w = !mapped_w ? 32'h0000_0000 :
                        hit_ctrl  ? {21'h0, ctrl_q} :
                                    32'(timer_q);

  // Control register; the mask keeps all 11 bits, and bits 31:11 read 0 through the read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CUT_CTRL_RST[10:0];
    end else begin
      ctrl_q <= ctrl_d & CUT_CTRL_MASK;
    end
  end

  // Timer register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= TIMER_W'(CUT_TIMER_RST);
    end else begin
      timer_q <= timer_d;
    end
  end

  // Prescaler runs free, so the first tick after a start may come early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + CUT_PRE_W'(1);
    end
  end

  // Previous synchronised count sample; reset matches the idle pin level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_prev_q <= 1'b0;
    end else begin
      cnt_prev_q <= cnt_s;
    end
  end

  // Ready follows every setup cycle, so the access phase has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_w;
    end
  end

  // Error flags an unmapped address together with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_w && !mapped_w;
    end
  end

  // Read data is captured in the setup cycle and holds until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      if (setup_w && !pwrite) begin
        prdata <= rdata_w;
      end
    end
  end

  // Pin shows the latch in step with its register bit, or the ordinary port level one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_output_pin <= 1'b0;
    end else begin
      toggle_output_pin <= toe_w ? ctrl_d[CUT_TLATCH_BIT] : gpio_out;
    end
  end

  // Latch copy for the auxiliary timers, independent of the pin enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_latch_out <= 1'b0;
    end else begin
      toggle_latch_out <= ctrl_d[CUT_TLATCH_BIT];
    end
  end

  // One-cycle wrap event for reload triggering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_pulse <= 1'b0;
    end else begin
      wrap_pulse <= wrap_w;
    end
  end
endmodule

// *** verification/cut_monitor.sv ***
// Port checker for the core up/down timer.
// Assumes zero-wait APB and a registered latch copy.
`timescale 1ns/1ps
module cut_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Latch routing
  input wire logic        toggle_latch_out,
  input wire logic        wrap_pulse
);
  logic lw_q;
  wire  cw = psel && penable && pready && pwrite && paddr == 32'h0 && pstrb[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lw_q <= 1'b0;
    else if (cw) lw_q <= pwdata[10];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pready |-> pslverr == (paddr != 32'h0 && paddr != 32'h4); endproperty
  property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_wrap; wrap_pulse |=> !wrap_pulse; endproperty
  // Software write wins over a wrap, so recent writes are excluded
  property p_tog; wrap_pulse && !$past(cw) && !$past(cw, 2)
    |-> toggle_latch_out != $past(toggle_latch_out); endproperty
  property p_hold; !wrap_pulse && !$past(cw) && !$past(cw, 2)
    |-> $stable(toggle_latch_out); endproperty
  property p_lw; cw |=> ##[0:1] toggle_latch_out == lw_q; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_rd0: assert property (p_rd0) else $error("refused read not zero");
  a_wrap: assert property (p_wrap) else $error("wrap pulse too long");
  a_tog: assert property (p_tog) else $error("wrap did not toggle latch");
  a_hold: assert property (p_hold) else $error("latch moved without cause");
  a_lw: assert property (p_lw) else $error("latch write lost");
endmodule
bind cut_core_timer cut_monitor i_cut_monitor (.*);

// *** verification/cut_pins.sv ***
// Model of the far side: count or gate pin and direction pin.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module cut_pins (
  input  wire logic pclk,
  output logic      cnt_pin,
  output logic      dir_pin
);
  initial begin
    cnt_pin = 1'b0;
    dir_pin = 1'b0;
  end
  task automatic lvl(input logic c, input logic d);
    @(posedge pclk);
    cnt_pin <= c;
    dir_pin <= d;
  endtask
  // Each level held eight clocks, so the rate stays at clock over sixteen
  task automatic pulse(input int n);
    repeat (2 * n) begin
      @(posedge pclk);
      cnt_pin <= !cnt_pin;
      repeat (7) @(posedge pclk);
    end
  endtask
endmodule

// *** verification/tb_cut_core_timer.sv ***
// Testbench for the core up/down timer.
// Assumes zero-wait APB slave and the pin model.
`timescale 1ns/1ps
module tb_cut_core_timer;
  import cut_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gpio_out = 1'b0, rerr, pready, pslverr, cnt_pin, dir_pin, top, tlo, wp;
  logic [31:0] paddr = '0, pwdata = '0, rdv, prdata;
  logic [3:0] pstrb = 4'h3;
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  always #20 pclk = !pclk;
  cut_pins i_cut_pins (.pclk(pclk), .cnt_pin(cnt_pin), .dir_pin(dir_pin));
  cut_core_timer i_cut_core_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_gate_input_pin(cnt_pin),
    .direction_input_pin(dir_pin), .gpio_out(gpio_out), .toggle_output_pin(top),
    .toggle_latch_out(tlo), .wrap_pulse(wp));
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run needs under 20000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin err_count++; complete_run(); end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 32'h0, 0); chk(rdv, 0);
    xfer(0, 32'h8, 0); chk({31'h0, rerr}, 1);
    // Port level differs from the latch, so each pin check tells the sources apart
    gpio_out <= 1'b0;
    xfer(1, 0, 32'h400); xfer(0, 0, 0); chk(rdv, 32'h400);
    chk(tlo, 1); chk(top, 0);
    xfer(1, 0, 32'h600); repeat (3) @(posedge pclk); chk(top, 1);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      n = (8 << i) * 5 / 2 - 2;
      xfer(1, 0, 32'(i) | (i[0] ? 32'hC0 : 32'h40));
      xfer(1, 32'h4, i[0] ? 32'h0 : 32'hFFFF);
      while (wp !== 1'b1) @(posedge pclk);
      chk(tlo, 1);
      repeat (n) @(posedge pclk);
      xfer(0, 32'h4, 0); chk(rdv, i[0] ? 32'hFFFD : 32'h2);
    end
    $display("timer test done");
    for (int j = 0; j < 8; j++) begin
      i_cut_pins.lvl(j[0], 1'b0);
      xfer(1, 0, (j[2] ? 32'h18 : 32'h10) | (j[1] ? 32'h40 : 32'h0));
      xfer(1, 32'h4, 0); repeat (80) @(posedge pclk);
      xfer(0, 32'h4, 0); chk(rdv != 0, j[1] && (j[0] == j[2]));
    end
    $display("gated test done");
    for (int e = 0; e < 5; e++) begin
      n = (e == 3) ? 4 : (e == 1 || e == 2) ? 2 : 0;
      i_cut_pins.lvl(1'b0, e[0]);
      xfer(1, 0, 32'h148 | (e[1] ? 32'h80 : 32'h0) | 32'(e));
      xfer(1, 32'h4, 0); i_cut_pins.pulse(2); repeat (4) @(posedge pclk);
      xfer(0, 32'h4, 0); chk(rdv, (e[0] ^ e[1]) ? 32'((-n) & 16'hFFFF) : n);
    end
    $display("counter test done");
    complete_run();
  end
endmodule
